// file: design/pmt_consts.svh
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH
// register map, one aligned word per register, instance stride 0x10
`define PMT_INST_STRIDE   8'h10
`define PMT_OFF_CONTROL   8'h00
`define PMT_OFF_COUNT     8'h04
`define PMT_OFF_PERIOD    8'h08
`define PMT_OFF_IRQ_FLAG  8'h30
`define PMT_OFF_IRQ_EN    8'h34
// control fields
`define PMT_CTL_POST_HI   6
`define PMT_CTL_POST_LO   3
`define PMT_CTL_EN_BIT    2
`define PMT_CTL_PRE_HI    1
`define PMT_CTL_PRE_LO    0
// reset values
`define PMT_RST_CONTROL   8'h00
`define PMT_RST_COUNT     8'h00
`define PMT_RST_PERIOD    8'hff
// instruction clock is one quarter of the oscillator
`define PMT_ICLK_DIV      4
// prescaler terminal counts (divide minus one)
`define PMT_PRE_TC_1      6'h00
`define PMT_PRE_TC_4      6'h03
`define PMT_PRE_TC_16     6'h0f
`define PMT_PRE_TC_64     6'h3f
`endif

// file: design/pmt_pkg.sv
package pmt_pkg;
  typedef struct packed {
    logic [3:0] postscale_select;
    logic       timer_enable_bit;
    logic [1:0] prescale_select;
  } pmt_ctl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       wr_ctl;
    logic       wr_cnt;
    logic       wr_per;
  } pmt_wr_t;
endpackage

// file: design/pmt_timer.sv
`timescale 1ns/100ps
`include "pmt_consts.svh"

module pmt_timer #(
  parameter int NUM_TIMERS = 3
) (
  input  wire logic                  SYS_CLK,       // oscillator clock
  input  wire logic                  RST_B,         // any device reset
  input  wire logic                  SLEEP,         // processor asleep
  input  wire logic [7:0]            AWADDR,        // write address
  input  wire logic                  AWVALID,       // write address valid
  output logic                       AWREADY,       // write address ready
  input  wire logic [31:0]           WDATA,         // write data
  input  wire logic [3:0]            WSTRB,         // write strobes
  input  wire logic                  WVALID,        // write data valid
  output logic                       WREADY,        // write data ready
  output logic [1:0]                 BRESP,         // write response
  output logic                       BVALID,        // write response valid
  input  wire logic                  BREADY,        // response ready
  input  wire logic [7:0]            ARADDR,        // read address
  input  wire logic                  ARVALID,       // read address valid
  output logic                       ARREADY,       // read address ready
  output logic [31:0]                RDATA,         // read data
  output logic [1:0]                 RRESP,         // read response
  output logic                       RVALID,        // read data valid
  input  wire logic                  RREADY,        // read data ready
  output logic [NUM_TIMERS-1:0]      MATCH,         // unscaled match pulses
  output logic                       SHIFT_CLK,     // serial shift clock
  output logic                       IRQ            // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // instruction clock enable

  logic [1:0] iclk_cnt_r;
  logic       iclk_en;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      iclk_cnt_r <= 2'h0;
    end else begin
      iclk_cnt_r <= iclk_cnt_r + 2'h1;
    end
  end

  assign iclk_en = (iclk_cnt_r == 2'(`PMT_ICLK_DIV - 1)) && !SLEEP;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order

  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        wr_go;
  logic        wr_ok;
  logic [7:0]  wr_addr;

  assign AWREADY = !aw_held_r && !bvalid_r;
  assign WREADY  = !w_held_r && !bvalid_r;
  assign BVALID  = bvalid_r;
  assign BRESP   = bresp_r;
  assign wr_go   = aw_held_r && w_held_r && !bvalid_r;
  assign wr_addr = awaddr_r;
  // byte lane 0 carries all register bits; other lanes are ignored
  assign wr_ok   = wr_go && wstrb_r[0];

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held_r <= 1'b1;
        wdata_r  <= WDATA;
        wstrb_r  <= WSTRB;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_mapped(wr_addr) ? 2'h0 : 2'h2;
      end else if (bvalid_r && BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  function automatic logic wr_mapped(input logic [7:0] a);
    logic [7:0] off;
    off = a & 8'h0f;
    if (a == `PMT_OFF_IRQ_FLAG || a == `PMT_OFF_IRQ_EN) begin
      return 1'b1;
    end
    return (a < 8'(NUM_TIMERS * `PMT_INST_STRIDE)) &&
           (off == `PMT_OFF_CONTROL || off == `PMT_OFF_COUNT ||
            off == `PMT_OFF_PERIOD);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // timer instances

  pmt_pkg::pmt_ctl_t  ctl_r   [NUM_TIMERS];
  logic [7:0]         cnt_r   [NUM_TIMERS];
  logic [7:0]         per_r   [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] match;
  logic [NUM_TIMERS-1:0] post_hit;
  logic [NUM_TIMERS-1:0] irq_flag_r;
  logic [NUM_TIMERS-1:0] irq_en_r;
  logic [NUM_TIMERS-1:0] flag_rd_clr;

  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
    logic [5:0] pre_r;
    logic [5:0] pre_tc;
    logic [3:0] post_r;
    logic       tick;
    logic       sel;
    logic       clr_scalers;
    logic [7:0] base;

    assign base = 8'(i * `PMT_INST_STRIDE);
    assign sel  = wr_ok && ((wr_addr & 8'hf0) == base);
    assign clr_scalers = sel && (wr_addr[3:0] == `PMT_OFF_COUNT ||
                                 wr_addr[3:0] == `PMT_OFF_CONTROL);

    always_comb begin
      unique case (ctl_r[i].prescale_select)
        2'h0: pre_tc = `PMT_PRE_TC_1;
        2'h1: pre_tc = `PMT_PRE_TC_4;
        2'h2: pre_tc = `PMT_PRE_TC_16;
        2'h3: pre_tc = `PMT_PRE_TC_64;
      endcase
    end

    assign tick = iclk_en && ctl_r[i].timer_enable_bit &&
                  (pre_r == pre_tc);
    assign match[i] = (cnt_r[i] == per_r[i]);
    assign post_hit[i] = tick && match[i] &&
                         (post_r == ctl_r[i].postscale_select);

    // prescaler advances on instruction clock while enabled
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
        pre_r <= 6'h00;
      end else if (clr_scalers) begin
        pre_r <= 6'h00;
      end else if (iclk_en && ctl_r[i].timer_enable_bit) begin
        pre_r <= (pre_r >= pre_tc) ? 6'h00 : pre_r + 6'h01;
      end
    end

    // match is acted on at the timer tick, so the count clears next tick
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
        post_r <= 4'h0;
      end else if (clr_scalers) begin
        post_r <= 4'h0;
      end else if (tick && match[i]) begin
        post_r <= post_hit[i] ? 4'h0 : post_r + 4'h1;
      end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
        ctl_r[i] <= pmt_pkg::pmt_ctl_t'(7'(`PMT_RST_CONTROL));
      end else if (sel && wr_addr[3:0] == `PMT_OFF_CONTROL) begin
        ctl_r[i] <= pmt_pkg::pmt_ctl_t'(wdata_r[6:0]);
      end
    end

    // software write wins over counting in the same cycle
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
        cnt_r[i] <= `PMT_RST_COUNT;
      end else if (sel && wr_addr[3:0] == `PMT_OFF_COUNT) begin
        cnt_r[i] <= wdata_r[7:0];
      end else if (tick) begin
        cnt_r[i] <= match[i] ? 8'h00 : cnt_r[i] + 8'h01;
      end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
        per_r[i] <= `PMT_RST_PERIOD;
      end else if (sel && wr_addr[3:0] == `PMT_OFF_PERIOD) begin
        per_r[i] <= wdata_r[7:0];
      end
    end

    // set beats the clear-on-read in the same cycle
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
        irq_flag_r[i] <= 1'b0;
      end else if (post_hit[i]) begin
        irq_flag_r[i] <= 1'b1;
      end else if (flag_rd_clr[i]) begin
        irq_flag_r[i] <= 1'b0;
      end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
        MATCH[i] <= 1'b0;
      end else begin
        MATCH[i] <= tick && match[i];
      end
    end

    // a match seen at a tick, with no software write racing it
    sequence s_hit_free;
      tick && match[i] && !sel;
    endsequence

    sequence s_cnt_zero;
      cnt_r[i] == 8'h00;
    endsequence

    a_match_clears: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B)
      s_hit_free |=> s_cnt_zero)
      else $error("count not cleared after match");
    a_count_steps: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B)
      (tick && !match[i] && !sel) |=> (cnt_r[i] == $past(cnt_r[i]) + 8'h01))
      else $error("count did not step by one");
    a_match_pulse: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B)
      (tick && match[i]) |=> MATCH[i])
      else $error("match pulse missing");
    a_hold_disabled: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B)
      (!ctl_r[i].timer_enable_bit && !sel) |=> $stable(cnt_r[i]))
      else $error("count moved while disabled");
    a_sleep_hold: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B)
      (SLEEP && !sel) |=> $stable(cnt_r[i]) && $stable(per_r[i]))
      else $error("count moved during sleep");
    a_wr_clears: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B)
      clr_scalers |=> (pre_r == 6'h00) && (post_r == 4'h0))
      else $error("scalers not cleared by write");
    a_flag_sets: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B)
      post_hit[i] |=> irq_flag_r[i])
      else $error("flag not set at postscale terminal");
    a_flag_clears: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B)
      (flag_rd_clr[i] && !post_hit[i]) |=> !irq_flag_r[i])
      else $error("flag not cleared by read");
    a_div_one: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B)
      (iclk_en && ctl_r[i].timer_enable_bit &&
       ctl_r[i].prescale_select == 2'h0) |-> tick)
      else $error("divide by one missed a tick");
  end

  assign IRQ       = |(irq_flag_r & irq_en_r);
  assign SHIFT_CLK = MATCH[0];

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_en_r <= '0;
    end else if (wr_ok && wr_addr == `PMT_OFF_IRQ_EN) begin
      irq_en_r <= wdata_r[NUM_TIMERS-1:0];
    end
  end

  // an enabled terminal count must reach the request one cycle later
  a_irq_follows: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    (|(post_hit & irq_en_r) && !(wr_ok && wr_addr == `PMT_OFF_IRQ_EN))
    |=> IRQ)
    else $error("unmasked flag raised no interrupt");
  a_irq_gate: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    (irq_en_r == '0) |-> !IRQ)
    else $error("interrupt not gated by enable");

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel, one cycle after address

  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic        rd_go;
  int          rd_idx;

  assign ARREADY = !rvalid_r;
  assign RVALID  = rvalid_r;
  assign RDATA   = rdata_r;
  assign RRESP   = rresp_r;
  assign rd_go   = ARVALID && ARREADY;
  assign flag_rd_clr = (rd_go && ARADDR == `PMT_OFF_IRQ_FLAG) ?
                       {NUM_TIMERS{1'b1}} : '0;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = wr_mapped(ARADDR);
    rd_idx = int'(ARADDR[7:4]);
    if (ARADDR == `PMT_OFF_IRQ_FLAG) begin
      rd_val = 32'(irq_flag_r);
    end else if (ARADDR == `PMT_OFF_IRQ_EN) begin
      rd_val = 32'(irq_en_r);
    end else if (rd_hit && rd_idx < NUM_TIMERS) begin
      unique case (ARADDR[3:0])
        `PMT_OFF_CONTROL: rd_val = 32'(ctl_r[rd_idx]);   // bit 7 reads zero
        `PMT_OFF_COUNT:   rd_val = 32'(cnt_r[rd_idx]);
        default:          rd_val = 32'(per_r[rd_idx]);
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= 2'h0;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_hit ? 2'h0 : 2'h2;
    end else if (rvalid_r && RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// file: verification/pmt_consumer.sv
`timescale 1ns/100ps
// stands in for the compare units and the serial port that use the pulses
module pmt_consumer (
  input  wire logic       clk,       // system clock
  input  wire logic       rst_b,     // async reset
  input  wire logic [2:0] match,     // time base pulses
  input  wire logic       shift_clk, // serial shift clock
  output int              pulses,    // time base pulses of first unit
  output int              bad        // cycles where shift clock strays
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulses <= 0;
      bad    <= 0;
    end else begin
      if (match[0] === 1'b1) pulses <= pulses + 1;
      if (shift_clk !== match[0]) bad <= bad + 1;
    end
  end
endmodule

// file: verification/tb_period_match_timer8.sv
`timescale 1ns/100ps
`include "pmt_consts.svh"
module tb_period_match_timer8;
  logic        SYS_CLK, RST_B, SLEEP, IRQ, SHIFT_CLK;
  logic [7:0]  AWADDR, ARADDR;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  logic [31:0] WDATA, RDATA, rd_d, a0;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rd_r, wr_b;
  logic [2:0]  MATCH;
  int          failures, checks_done, cyc, pulses, bad;
  int          g, n, p, i, per, dv, v;

  pmt_timer #(.NUM_TIMERS(3)) i_dut (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .SLEEP(SLEEP),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .MATCH(MATCH), .SHIFT_CLK(SHIFT_CLK), .IRQ(IRQ));

  pmt_consumer i_far (.clk(SYS_CLK), .rst_b(RST_B), .match(MATCH),
    .shift_clk(SHIFT_CLK), .pulses(pulses), .bad(bad));

  initial begin
    SYS_CLK = 0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // the cycle ceiling covers every test with a wide margin
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      $display("[FAIL] %0t timeout", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] ad(input int k, input logic [7:0] off);
    return 8'(k) * `PMT_INST_STRIDE + off;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge SYS_CLK);
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1;
    WVALID  <= 1;
    BREADY  <= 1;
    while (!(aw && w)) begin
      @(negedge SYS_CLK);
      aw = aw | (AWVALID & AWREADY);
      w  = w | (WVALID & WREADY);
      @(posedge SYS_CLK);
      if (aw) AWVALID <= 0;
      if (w) WVALID <= 0;
    end
    do @(negedge SYS_CLK); while (BVALID !== 1'b1);
    wr_b = BRESP;
    @(posedge SYS_CLK);
    BREADY <= 0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge SYS_CLK);
    ARADDR  <= a;
    ARVALID <= 1;
    RREADY  <= 1;
    do @(negedge SYS_CLK); while (ARREADY !== 1'b1);
    @(posedge SYS_CLK);
    ARVALID <= 0;
    do @(negedge SYS_CLK); while (RVALID !== 1'b1);
    rd_d = RDATA;
    rd_r = RRESP;
    @(posedge SYS_CLK);
    RREADY <= 0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_d, exp);
  endtask

  // cycles between two consecutive pulses of one unit
  task automatic gap(input int k);
    do @(negedge SYS_CLK); while (MATCH[k] !== 1'b1);
    g = 0;
    do begin
      @(negedge SYS_CLK);
      g++;
    end while (MATCH[k] !== 1'b1);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    {SLEEP, AWADDR, ARADDR, AWVALID, WVALID, BREADY} = '0;
    {ARVALID, RREADY, WDATA} = '0;
    WSTRB = 4'hf;
    RST_B = 0;
    void'($urandom(73));
    repeat (16) @(posedge SYS_CLK);
    RST_B <= 1;
    for (int k = 0; k < 3; k++) begin
      rchk(ad(k, `PMT_OFF_CONTROL), 32'h00);
      rchk(ad(k, `PMT_OFF_COUNT), 32'h00);
      rchk(ad(k, `PMT_OFF_PERIOD), 32'hff);
    end
    rd(8'h3c);
    chk({30'h0, rd_r}, 32'h2);
    chk(rd_d, 32'h0);
    wr(8'h3c, 32'h1);
    chk({30'h0, wr_b}, 32'h2);
    // lane 0 strobe low: the write is answered but changes nothing
    WSTRB <= 4'he;
    wr(ad(0, `PMT_OFF_PERIOD), 32'h12);
    WSTRB <= 4'hf;
    chk({30'h0, wr_b}, 32'h0);
    rchk(ad(0, `PMT_OFF_PERIOD), 32'hff);
    wr(ad(1, `PMT_OFF_CONTROL), 32'hff);
    rchk(ad(1, `PMT_OFF_CONTROL), 32'h7f);
    wr(ad(1, `PMT_OFF_CONTROL), 32'h00);
    for (int k = 0; k < 3; k++) begin
      v = $urandom_range(255, 0);
      wr(ad(k, `PMT_OFF_COUNT), 32'(v));
      rchk(ad(k, `PMT_OFF_COUNT), 32'(v));
      wr(ad(k, `PMT_OFF_PERIOD), 32'(v ^ 8'h5a));
      rchk(ad(k, `PMT_OFF_PERIOD), 32'(v ^ 8'h5a));
    end
    // every prescale code, spread over the three units
    for (int ps = 0; ps < 4; ps++) begin
      i = ps % 3;
      per = $urandom_range(3, 1);
      dv = 1 << (2 * ps);
      wr(ad(i, `PMT_OFF_PERIOD), 32'(per));
      wr(ad(i, `PMT_OFF_COUNT), 32'h0);
      wr(ad(i, `PMT_OFF_CONTROL), 32'(4 | ps));
      gap(i);
      chk(g, 4 * dv * (per + 1));
      wr(ad(i, `PMT_OFF_CONTROL), 32'h0);
    end
    p = $urandom_range(3, 0);
    i = $urandom_range(2, 0);
    wr(ad(i, `PMT_OFF_PERIOD), 32'h1);
    wr(ad(i, `PMT_OFF_COUNT), 32'h0);
    rd(`PMT_OFF_IRQ_FLAG);
    wr(`PMT_OFF_IRQ_EN, 32'(1 << i));
    @(negedge SYS_CLK);
    chk({31'h0, IRQ}, 32'h0);
    wr(ad(i, `PMT_OFF_CONTROL), 32'((p << 3) | 4));
    n = 0;
    do begin
      @(negedge SYS_CLK);
      if (MATCH[i] === 1'b1) n++;
    end while (IRQ !== 1'b1);
    chk(n, p + 1);
    wr(ad(i, `PMT_OFF_CONTROL), 32'h0);
    rchk(`PMT_OFF_IRQ_FLAG, 32'(1 << i));
    @(negedge SYS_CLK);
    chk({31'h0, IRQ}, 32'h0);
    rchk(`PMT_OFF_IRQ_FLAG, 32'h0);
    // masked: flag still latches but the request stays low
    wr(`PMT_OFF_IRQ_EN, 32'h0);
    wr(ad(i, `PMT_OFF_CONTROL), 32'h4);
    gap(i);
    repeat (2) @(negedge SYS_CLK);
    chk({31'h0, IRQ}, 32'h0);
    wr(ad(i, `PMT_OFF_CONTROL), 32'h0);
    rchk(`PMT_OFF_IRQ_FLAG, 32'(1 << i));
    // disabled, then asleep: the count must not move
    wr(ad(2, `PMT_OFF_PERIOD), 32'hff);
    for (int k = 0; k < 2; k++) begin
      wr(ad(2, `PMT_OFF_CONTROL), 32'(k * 4));
      if (k == 1) SLEEP <= 1;
      rd(ad(2, `PMT_OFF_COUNT));
      a0 = rd_d;
      repeat (200) @(posedge SYS_CLK);
      rchk(ad(2, `PMT_OFF_COUNT), a0);
      rchk(ad(2, `PMT_OFF_PERIOD), 32'hff);
    end
    SLEEP <= 0;
    chk(32'(bad), 32'h0);
    chk({31'h0, pulses != 0}, 32'h1);
    complete_run();
  end
endmodule
